// file: hw/alarm_history_mem.sv
`timescale 1ns/100ps
// small list of channel indices in first-seen order
module alarm_history_mem
  import alarm_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic wr_en,
  input wire logic [CH_W-1:0] wr_addr,
  input wire logic [CH_W-1:0] wr_data,
  input wire logic [CH_W-1:0] rd_addr,
  output logic [CH_W-1:0] rd_data
);
  logic [CH_W-1:0] mem_reg [NUM_CH]; // one slot per possible channel

  // write port and registered read port
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < NUM_CH; i++)
        mem_reg[i] <= '0;
      rd_data <= '0;
    end
    else
    begin
      if (wr_en)
        mem_reg[wr_addr] <= wr_data;
      rd_data <= mem_reg[rd_addr];
    end
  end
endmodule // alarm_history_mem

// file: hw/alarm_pkg.sv
// How it works
// - open closed-loop input raises its channel alarm
// - local alarm on receive channel cuts load
// - local alarm on send channel goes out
// - bus alarm on receive channel cuts load
// - self-test at power-up and single-panel press
// - six checks in order, failure blinks fault
// - low purge pressure gives five fault blinks
// - press replays bus alarm codes three times
// - another press restarts the replay
// - code is channel number plus one blinks, then pause
// - press with empty history runs self-test
// - power lamp steady, blinks awaiting bus
// - alarm lamp dark without any alarm
// - alarm lamp steady after bus shutdown
// - alarm lamp blinks for a local alarm
// - fast blink after clear until alarms gone
// - send only in own ascending poll slot
// - four-bit field is slave count or address
// - four channels, own send and receive selects
package alarm_pkg;
  // ****************************************************************
  // channel and bus geometry
  // ****************************************************************
  localparam int NUM_CH = 4; // alarm channels per panel
  localparam int CH_W = 2; // width of a channel index
  localparam int ADDR_W = 4; // bus address or slave count
  localparam int CNT_W = 3; // history fill count, 0..4
  localparam logic [ADDR_W-1:0] MASTER_SLOT = 4'h0; // master polls itself first

  // ****************************************************************
  // register map, byte addresses on the word bus
  // ****************************************************************
  localparam logic [3:0] CONFIG_OFS = 4'h0; // selections and role
  localparam logic [3:0] STATUS_OFS = 4'h4; // live state, read only
  localparam logic [3:0] COMMAND_OFS = 4'h8; // write-only commands
  localparam logic [3:0] NC_RESET = 4'hF; // all inputs closed-loop by default
  localparam int CMD_CLEAR_BIT = 0; // clear interlocks command
  localparam logic [31:0] CFG_MASK = 32'h000F_1FFF; // writable config bits, rest read 0

  // ****************************************************************
  // timing, in printed units and derived cycle counts
  // ****************************************************************
  localparam int CLOCK_HZ = 50000000;
  localparam int SLOW_MS = 250; // normal blink half period
  localparam int FAST_MS = 50; // fast blink half period
  localparam int POLL_US = 100; // length of one poll slot
  localparam int SLOW_CYCLES = CLOCK_HZ / 1000 * SLOW_MS;
  localparam int FAST_CYCLES = CLOCK_HZ / 1000 * FAST_MS;
  localparam int POLL_CYCLES = CLOCK_HZ / 1000000 * POLL_US;
  localparam logic [2:0] GAP_TICKS = 3'h4; // pause between codes
  localparam logic [1:0] REPEATS = 2'h3; // replay passes
  localparam logic [2:0] PURGE_BLINKS = 3'h5; // low purge blink count
  localparam logic [2:0] LAST_STEP = 3'h5; // purge check is last
  localparam logic [2:0] LAMP_STEP = 3'h0; // indicator check lights all

  // ****************************************************************
  // carriers and states
  // ****************************************************************
  typedef struct packed {
    logic [3:0] recv_sel; // upper nibble of byte 0
    logic [3:0] send_sel;
  } select_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr_count; // count on master, address on slave
    logic [2:0] spare; // unused, keeps the count in bits 19:16
    logic master;
    logic [3:0] nc_sel;
    select_type sel;
  } config_type;

  typedef struct packed {
    logic read;
    logic write;
    logic [3:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } avalon_req_type;

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_PURGE} test_state_type;
  typedef enum logic [1:0] {PB_IDLE, PB_ON, PB_OFF, PB_GAP} play_state_type;
endpackage

// file: hw/interlock_alarm_indicator_logic.sv
// Added by the designer: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/100ps
module interlock_alarm_indicator_logic
  import alarm_pkg::*;
#(
  parameter int SLOW_DIV = SLOW_CYCLES,
  parameter int FAST_DIV = FAST_CYCLES,
  parameter int POLL_DIV = POLL_CYCLES
)
(
  input wire logic clock,
  input wire logic rstn,
  input wire avalon_req_type avs_req,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [NUM_CH-1:0] interlock_in,
  input wire logic test_button,
  input wire logic purge_low,
  input wire logic [4:0] check_fail,
  input wire logic [NUM_CH-1:0] bus_alarm_in,
  input wire logic [ADDR_W-1:0] poll_addr_in,
  output logic [NUM_CH-1:0] bus_alarm_out,
  output logic bus_alarm_oe,
  output logic [ADDR_W-1:0] poll_addr_out,
  output logic poll_addr_oe,
  output logic load_on,
  output logic power_lamp,
  output logic alarm_lamp,
  output logic fault_lamp
);
  // ****************************************************************
  // helpers
  // ****************************************************************
  // lowest set bit index, used to pick the channel written to history
  function automatic logic [CH_W-1:0] lowest(input logic [NUM_CH-1:0] v);
    lowest = '0;
    for (int i = NUM_CH - 1; i >= 0; i--)
      if (v[i])
        lowest = CH_W'(i);
  endfunction

  // byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    for (int b = 0; b < 4; b++)
      merge[b*8 +: 8] = be[b] ? wd[b*8 +: 8] : old[b*8 +: 8];
  endfunction

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  localparam int SYNC_W = 2 * NUM_CH + ADDR_W + 2;
  logic [SYNC_W-1:0] sync1_reg; // first stage, read only by the second
  logic [SYNC_W-1:0] sync2_reg; // safe copy
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end
    else
    begin
      sync1_reg <= {interlock_in, bus_alarm_in, poll_addr_in, test_button, purge_low};
      sync2_reg <= sync1_reg;
    end
  end
  wire [NUM_CH-1:0] contact = sync2_reg[SYNC_W-1 -: NUM_CH];
  wire [NUM_CH-1:0] bus_seen = sync2_reg[SYNC_W-NUM_CH-1 -: NUM_CH];
  wire [ADDR_W-1:0] poll_seen = sync2_reg[ADDR_W+1:2];
  wire button = sync2_reg[1];
  wire purge_bad = sync2_reg[0];

  // ****************************************************************
  // register bus slave
  // ****************************************************************
  config_type cfg_reg; // selections, polarity, role, address
  logic button_reg; // previous button level for edge detect
  logic [NUM_CH-1:0] bus_latch_reg; // held bus alarms until clear
  logic [NUM_CH-1:0] recorded_reg; // channels already in history
  logic [CNT_W-1:0] hist_cnt_reg; // history fill
  logic fast_reg; // fast blink after manual clear
  logic fault_reg; // self-test found a fault
  test_state_type st_reg;
  play_state_type pb_reg;

  wire req = avs_req.read | avs_req.write;
  wire accept = req & ~avs_waitrequest; // the edge the master sees waitrequest low
  wire wr_cfg = accept & avs_req.write & (avs_req.address == CONFIG_OFS);
  wire clear_cmd = accept & avs_req.write & (avs_req.address == COMMAND_OFS)
                   & avs_req.byteenable[0] & avs_req.writedata[CMD_CLEAR_BIT];
  wire [NUM_CH-1:0] local_alarm = contact ^ cfg_reg.nc_sel;
  wire shutdown = |((local_alarm | bus_latch_reg) & cfg_reg.sel.recv_sel);
  wire [31:0] status_word = {16'h0000, fast_reg, hist_cnt_reg, fault_reg, pb_reg != PB_IDLE,
                             st_reg != ST_IDLE, shutdown, bus_latch_reg, local_alarm};
  wire [31:0] cfg_merged = merge(32'(cfg_reg), avs_req.writedata, avs_req.byteenable)
                           & CFG_MASK;
  wire [31:0] read_word = (avs_req.address == CONFIG_OFS) ? 32'(cfg_reg) :
                          (avs_req.address == STATUS_OFS) ? status_word : 32'h0000_0000;

  // one wait cycle, then a single answer cycle; unmapped reads give zero
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      cfg_reg <= '{addr_count: 4'h0, spare: 3'h0, master: 1'b0, nc_sel: NC_RESET, sel: '0};
    end
    else
    begin
      avs_waitrequest <= ~(req & avs_waitrequest);
      if (req & avs_waitrequest)
        avs_readdata <= avs_req.read ? read_word : 32'h0000_0000;
      if (wr_cfg)
        cfg_reg <= config_type'(cfg_merged[$bits(config_type)-1:0]);
    end
  end

  // ****************************************************************
  // rate enables
  // ****************************************************************
  logic slow_tick; // blink and test step pace
  logic fast_tick; // fast blink pace
  logic poll_tick; // poll slot pace
  tick_divider #(.COUNT(SLOW_DIV)) slow_div (.clock(clock), .rstn(rstn), .tick(slow_tick));
  tick_divider #(.COUNT(FAST_DIV)) fast_div (.clock(clock), .rstn(rstn), .tick(fast_tick));
  tick_divider #(.COUNT(POLL_DIV)) poll_div (.clock(clock), .rstn(rstn), .tick(poll_tick));

  // ****************************************************************
  // interlock bus: polling and broadcast
  // ****************************************************************
  logic [ADDR_W-1:0] slot_reg; // master's current poll address
  wire polled_me = cfg_reg.master ? (slot_reg == MASTER_SLOT)
                                  : (poll_seen == cfg_reg.addr_count);
  wire [NUM_CH-1:0] to_send = local_alarm & cfg_reg.sel.send_sel;
  wire waiting = (|to_send) & ~polled_me;

  // master steps 0..count upward; slaves answer only in their slot
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      slot_reg <= MASTER_SLOT;
      poll_addr_out <= MASTER_SLOT;
      poll_addr_oe <= 1'b0;
      bus_alarm_out <= '0;
      bus_alarm_oe <= 1'b0;
    end
    else
    begin
      if (poll_tick)
        slot_reg <= (slot_reg >= cfg_reg.addr_count) ? MASTER_SLOT : slot_reg + 1'b1;
      poll_addr_out <= slot_reg;
      poll_addr_oe <= cfg_reg.master;
      bus_alarm_out <= polled_me ? to_send : '0;
      bus_alarm_oe <= polled_me;
    end
  end

  // ****************************************************************
  // latched bus alarms and the history list
  // ****************************************************************
  wire [NUM_CH-1:0] fresh = bus_latch_reg & ~recorded_reg;
  wire hist_wr = |fresh;
  wire [CH_W-1:0] fresh_ch = lowest(fresh);
  logic [CH_W-1:0] idx_reg; // replay position
  logic [CH_W-1:0] code_ch; // channel stored at replay position
  alarm_history_mem history (.clock(clock), .rstn(rstn), .wr_en(hist_wr),
    .wr_addr(hist_cnt_reg[CH_W-1:0]), .wr_data(fresh_ch), .rd_addr(idx_reg), .rd_data(code_ch));

  // arriving alarm wins over a clear in the same cycle
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      bus_latch_reg <= '0;
      recorded_reg <= '0;
      hist_cnt_reg <= '0;
      fast_reg <= 1'b0;
    end
    else
    begin
      bus_latch_reg <= (clear_cmd ? '0 : bus_latch_reg) | bus_seen;
      if (clear_cmd)
      begin
        recorded_reg <= '0;
        hist_cnt_reg <= '0;
      end
      else if (hist_wr)
      begin
        recorded_reg[fresh_ch] <= 1'b1;
        hist_cnt_reg <= hist_cnt_reg + 1'b1;
      end
      if (clear_cmd)
        fast_reg <= 1'b1;
      else if (~|(local_alarm | bus_latch_reg))
        fast_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // test button: self-test or code replay
  // ****************************************************************
  wire press = button & ~button_reg;
  wire single = cfg_reg.master & (cfg_reg.addr_count == 4'h0);
  logic boot_reg; // power-up request not yet served
  wire start_test = boot_reg | (press & (single | hist_cnt_reg == '0));
  wire start_play = press & ~single & (hist_cnt_reg != '0);
  logic [2:0] step_reg; // self-test step or blink counter
  logic [2:0] blink_reg; // blinks or gap ticks done
  logic [1:0] rep_reg; // replay passes done
  logic purge_on_reg; // purge blink phase
  wire [2:0] code_len = 3'(code_ch) + 3'h1;
  wire step_fail = (step_reg < LAST_STEP) & check_fail[step_reg];
  wire last_code = (3'(idx_reg) + 3'h1) == hist_cnt_reg;

  // self-test walks the checks in order at the slow pace
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      boot_reg <= 1'b1;
      button_reg <= 1'b0;
      st_reg <= ST_IDLE;
      step_reg <= '0;
      fault_reg <= 1'b0;
      purge_on_reg <= 1'b0;
    end
    else
    begin
      boot_reg <= 1'b0;
      button_reg <= button;
      if (start_test)
      begin
        st_reg <= ST_RUN;
        step_reg <= '0;
        fault_reg <= 1'b0;
        purge_on_reg <= 1'b0; // a restart must not begin mid-blink
      end
      else if (slow_tick)
      begin
        unique case (st_reg)
          ST_IDLE:
            step_reg <= step_reg;
          ST_RUN:
          begin
            if (step_fail)
              fault_reg <= 1'b1;
            step_reg <= step_reg + 1'b1;
            if (step_reg == LAST_STEP)
            begin
              st_reg <= purge_bad ? ST_PURGE : ST_IDLE;
              step_reg <= '0;
            end
          end
          ST_PURGE:
          begin
            purge_on_reg <= ~purge_on_reg;
            if (purge_on_reg)
              step_reg <= step_reg + 1'b1;
            if (purge_on_reg & (step_reg == PURGE_BLINKS - 3'h1))
              st_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // replay: code blinks, pause, next code, three passes
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      pb_reg <= PB_IDLE;
      idx_reg <= '0;
      rep_reg <= '0;
      blink_reg <= '0;
    end
    else if (start_play)
    begin
      pb_reg <= PB_ON;
      idx_reg <= '0;
      rep_reg <= '0;
      blink_reg <= '0;
    end
    else if (slow_tick)
    begin
      unique case (pb_reg)
        PB_IDLE:
          blink_reg <= '0;
        PB_ON:
        begin
          pb_reg <= PB_OFF;
          blink_reg <= blink_reg + 1'b1;
        end
        PB_OFF:
        begin
          pb_reg <= (blink_reg == code_len) ? PB_GAP : PB_ON;
          if (blink_reg == code_len)
            blink_reg <= '0;
        end
        PB_GAP:
        begin
          blink_reg <= blink_reg + 1'b1;
          if (blink_reg == GAP_TICKS - 3'h1)
          begin
            blink_reg <= '0;
            idx_reg <= last_code ? '0 : idx_reg + 1'b1;
            if (last_code)
              rep_reg <= rep_reg + 1'b1;
            pb_reg <= (last_code & rep_reg == REPEATS - 2'h1) ? PB_IDLE : PB_ON;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // lamps and load
  // ****************************************************************
  logic slow_ph_reg; // slow blink phase
  logic fast_ph_reg; // fast blink phase
  wire lamp_check = (st_reg == ST_RUN) & (step_reg == LAMP_STEP);
  wire bus_shut = |(bus_latch_reg & cfg_reg.sel.recv_sel);
  wire alarm_next = lamp_check ? 1'b1 :
                    (pb_reg != PB_IDLE) ? (pb_reg == PB_ON) :
                    fast_reg ? fast_ph_reg :
                    (|local_alarm) ? slow_ph_reg :
                    bus_shut;
  wire fault_next = lamp_check | ((st_reg == ST_PURGE) ? purge_on_reg : fault_reg & slow_ph_reg);

  // a stuck-on lamp output could hide a real alarm, so all are registered
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      slow_ph_reg <= 1'b0;
      fast_ph_reg <= 1'b0;
      load_on <= 1'b0;
      power_lamp <= 1'b0;
      alarm_lamp <= 1'b0;
      fault_lamp <= 1'b0;
    end
    else
    begin
      slow_ph_reg <= slow_ph_reg ^ slow_tick;
      fast_ph_reg <= fast_ph_reg ^ fast_tick;
      load_on <= ~shutdown;
      power_lamp <= lamp_check | ~waiting | slow_ph_reg;
      alarm_lamp <= alarm_next;
      fault_lamp <= fault_next;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  a_nc_open_alarm: assert property (cfg_reg.nc_sel[0] & ~contact[0] |-> local_alarm[0])
    else $error("open closed-loop input not seen as alarm");
  a_local_cut_load: assert property ((|(local_alarm & cfg_reg.sel.recv_sel)) |=> !load_on)
    else $error("local alarm did not cut the load");
  a_bus_cut_load: assert property ((|(bus_seen & cfg_reg.sel.recv_sel)) |-> ##2 !load_on)
    else $error("bus alarm did not cut the load");
  a_send_in_slot: assert property (bus_alarm_oe |-> $past(polled_me) && bus_alarm_out == $past(to_send))
    else $error("broadcast outside own slot or wrong channels");
  a_test_on_press: assert property (press & single & ~boot_reg |=> st_reg == ST_RUN && step_reg == 3'h0)
    else $error("single-panel press did not start self-test");
  a_empty_runs_test: assert property (press & hist_cnt_reg == '0 |=> st_reg == ST_RUN)
    else $error("press with empty history did not self-test");
  a_fail_sets_fault: assert property (st_reg == ST_RUN & slow_tick & step_fail & ~start_test |=> fault_reg)
    else $error("failed check did not raise fault");
  a_replay_restart: assert property (start_play |=> pb_reg == PB_ON && idx_reg == '0 && rep_reg == '0)
    else $error("replay did not restart from the top");
  a_alarm_dark: assert property (pb_reg == PB_IDLE & st_reg == ST_IDLE & ~fast_reg
                                 & ~|local_alarm & ~bus_shut |=> !alarm_lamp)
    else $error("alarm lamp lit with no alarm");
  a_bus_steady: assert property (pb_reg == PB_IDLE & st_reg == ST_IDLE & ~fast_reg
                                 & ~|local_alarm & bus_shut |=> alarm_lamp)
    else $error("alarm lamp not steady on bus shutdown");
  a_power_steady: assert property (~waiting |=> power_lamp)
    else $error("power lamp dark while not waiting");
  a_history_once: assert property (hist_wr & ~clear_cmd |=> recorded_reg[$past(fresh_ch)])
    else $error("history entry not marked recorded");

  c_replay_run: cover property (start_play ##1 pb_reg == PB_ON);
  c_purge_blinks: cover property (st_reg == ST_PURGE ##1 st_reg == ST_IDLE);
  c_clear_fast: cover property (clear_cmd ##1 fast_reg);
  c_slave_sends: cover property (bus_alarm_oe & (|bus_alarm_out));
endmodule // interlock_alarm_indicator_logic

// file: hw/tick_divider.sv
`timescale 1ns/100ps
// one-cycle enable pulse every COUNT clocks
module tick_divider
#(
  parameter int COUNT = 16
)
(
  input wire logic clock,
  input wire logic rstn,
  output logic tick
);
  localparam int W = $clog2(COUNT + 1);
  localparam logic [W-1:0] LAST = W'(COUNT - 1);
  logic [W-1:0] count_reg; // cycles since last pulse

  // free-running count, pulse on wrap
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      count_reg <= '0;
      tick <= 1'b0;
    end
    else
    begin
      count_reg <= (count_reg == LAST) ? '0 : count_reg + 1'b1;
      tick <= (count_reg == LAST);
    end
  end
endmodule // tick_divider

// file: verification/panel_partner.sv
`timescale 1ns/100ps
// ****************************************************************
// far-side slave panel on the interlock bus
// ****************************************************************
module panel_partner
  import alarm_pkg::*;
#(
  parameter logic [ADDR_W-1:0] MY_ADDR = 4'h1
)
(
  input wire logic clock,
  input wire logic [ADDR_W-1:0] poll_addr,
  input wire logic [NUM_CH-1:0] alarms,
  output logic [NUM_CH-1:0] drive
);
  // speaks only in its own slot; released lines read 0 by the pull-down
  always_ff @(posedge clock)
  begin
    drive <= (poll_addr == MY_ADDR) ? alarms : 4'h0;
  end
endmodule // panel_partner

// file: verification/testbench.sv
`timescale 1ns/100ps
// ****************************************************************
// self-checking bench, master panel with one slave partner
// ****************************************************************
module testbench
  import alarm_pkg::*;
;
  logic clock = 0;
  logic rstn = 0;
  logic test_button = 0;
  logic purge_low = 0;
  logic [3:0] interlock_in = 4'hF; // all contacts closed
  logic [3:0] far_alarms = 4'h0; // what the partner broadcasts
  logic [3:0] far_drive;
  logic [4:0] check_fail = 5'h00;
  avalon_req_type req = '0;
  logic [31:0] rd;
  logic [31:0] rdata;
  logic wait_req, bus_oe, poll_oe, load_on, power_lamp, alarm_lamp, fault_lamp;
  logic [3:0] bus_out;
  logic [3:0] poll_out;
  // poll lines idle at a value no slave owns
  wire [3:0] poll_wire = poll_oe ? poll_out : 4'hF;
  // wired-or alarm lines of both panels
  wire [3:0] bus_wire = (bus_oe ? bus_out : 4'h0) | far_drive;
  integer seed = 32'h49d6;
  integer fail_count = 0;
  integer comparisons = 0;
  integer ch, rises, n;

  always #10 clock = ~clock;

  interlock_alarm_indicator_logic #(.SLOW_DIV(8), .FAST_DIV(4), .POLL_DIV(16)) dut
  (
    .clock(clock), .rstn(rstn), .avs_req(req), .avs_readdata(rd),
    .avs_waitrequest(wait_req), .interlock_in(interlock_in), .test_button(test_button),
    .purge_low(purge_low), .check_fail(check_fail), .bus_alarm_in(bus_wire),
    .poll_addr_in(poll_wire), .bus_alarm_out(bus_out), .bus_alarm_oe(bus_oe),
    .poll_addr_out(poll_out), .poll_addr_oe(poll_oe), .load_on(load_on),
    .power_lamp(power_lamp), .alarm_lamp(alarm_lamp), .fault_lamp(fault_lamp)
  );

  panel_partner far
  (
    .clock(clock), .poll_addr(poll_wire), .alarms(far_alarms), .drive(far_drive)
  );

  // config word: master with one slave, all inputs closed-loop
  function automatic logic [31:0] cfg(input logic [3:0] snd, input logic [3:0] rcv);
    return 32'h00011F00 | {24'h000000, rcv, snd};
  endfunction

  task chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask

  task chk_bit(input string nm, input logic e, input logic g);
    chk_word(nm, {31'h0, e}, {31'h0, g});
  endtask

  // one bus cycle, held until waitrequest is seen low
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    req <= '{read: !wr, write: wr, address: a, byteenable: 4'hF, writedata: d};
    do
    begin
      @(posedge clock);
    end
    while (wait_req !== 1'b0);
    rdata = rd;
    req <= '0;
  endtask

  // count rising edges of the alarm lamp (f=0) or fault lamp (f=1)
  task rises_in(input int cyc, input logic f);
    logic last;
    last = f ? fault_lamp : alarm_lamp;
    rises = 0;
    repeat (cyc)
    begin
      @(posedge clock);
      if ((f ? fault_lamp : alarm_lamp) === 1'b1 && last === 1'b0)
        rises++;
      last = f ? fault_lamp : alarm_lamp;
    end
  endtask

  task summarize;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // watchdog at 20000 cycles, far beyond the expected run of under two thousand cycles
  initial
  begin
    #400000;
    fail_count++;
    summarize;
  end

  initial
  begin
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    rises_in(20, 1'b1);
    chk_bit("boot lamp check", 1'b1, rises > 0);
    repeat (200) @(posedge clock);
    bus(1'b1, CONFIG_OFS, cfg(4'h1, 4'h1));
    bus(1'b0, CONFIG_OFS, 32'h0);
    chk_word("config", cfg(4'h1, 4'h1), rdata);
    bus(1'b0, 4'hC, 32'h0);
    chk_word("unmapped", 32'h0, rdata);
    chk_bit("lamp idle", 1'b0, alarm_lamp);
    chk_bit("power lamp", 1'b1, power_lamp);
    chk_bit("load idle", 1'b1, load_on);
    $display("config test done");
    // open contact on channel 0
    interlock_in <= 4'hE;
    repeat (8) @(posedge clock);
    chk_bit("local shutdown", 1'b0, load_on);
    n = 0;
    while (bus_oe !== 1'b1 && n < 100)
    begin
      @(posedge clock);
      n++;
    end
    chk_word("broadcast", 32'h1, {28'h0, bus_out});
    rises_in(60, 1'b0);
    chk_bit("local blink", 1'b1, rises > 1);
    interlock_in <= 4'hF;
    // let our own looped-back broadcast drain before clearing
    repeat (8) @(posedge clock);
    bus(1'b1, COMMAND_OFS, 32'h1);
    repeat (40) @(posedge clock);
    bus(1'b0, STATUS_OFS, 32'h0);
    chk_word("history cleared", 32'h0, {29'h0, rdata[14:12]});
    $display("local test done");
    // random bus channel from the partner
    ch = $unsigned($random(seed)) % 4;
    bus(1'b1, CONFIG_OFS, cfg(4'h0, 4'h1 << ch));
    far_alarms <= 4'h1 << ch;
    repeat (100) @(posedge clock);
    far_alarms <= 4'h0;
    chk_bit("bus shutdown", 1'b0, load_on);
    chk_bit("lamp steady", 1'b1, alarm_lamp);
    bus(1'b0, STATUS_OFS, 32'h0);
    chk_word("latched", 32'h1 << ch, {28'h0, rdata[7:4]});
    chk_word("history", 32'h1, {29'h0, rdata[14:12]});
    test_button <= 1'b1;
    rises_in(500, 1'b0);
    test_button <= 1'b0;
    chk_word("replay blinks", 3 * (ch + 1), rises);
    $display("replay test done");
    // empty history: a press runs self-test with low purge
    bus(1'b1, COMMAND_OFS, 32'h1);
    repeat (40) @(posedge clock);
    purge_low <= 1'b1;
    test_button <= 1'b1;
    rises_in(300, 1'b1);
    chk_word("purge blinks", 1 + PURGE_BLINKS, rises);
    $display("self-test done");
    // single panel: a press self-tests, one random check fails
    test_button <= 1'b0;
    purge_low <= 1'b0;
    check_fail <= 5'h01 << ($unsigned($random(seed)) % 5);
    bus(1'b1, CONFIG_OFS, 32'h00001F00);
    test_button <= 1'b1;
    rises_in(100, 1'b1);
    chk_bit("fault blink", 1'b1, rises > 1);
    bus(1'b0, STATUS_OFS, 32'h0);
    chk_bit("fault flag", 1'b1, rdata[11]);
    $display("single panel test done");
    summarize;
  end
endmodule // testbench
